// ### core/mex_core.sv
`timescale 1ns/1ps
module mex_core
    import mex_pkg::*;
#(
    parameter int FILE_DEPTH = 128,
    parameter int WDOG_W     = 8,
    parameter int PRESC_W    = 8
)(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Core state
    output logic             sleep_active,
    output logic             osc_enable,
    output logic             busy
);

    initial
    begin
        if (FILE_DEPTH != 128 || WDOG_W < 1 || WDOG_W > 8 || PRESC_W < 1 || PRESC_W > 8)
            $error("mex_core: unsupported parameter");
    end

    // ==========================================================
    // State
    typedef struct packed {
        mex_state_e   st;
        logic         pend;
        logic         pwr;
        logic [7:0]   paddr;
        logic [13:0]  instr;
        logic [7:0]   work;
        logic [12:0]  pc;
        logic [7:0]   status;
        logic [7:0]   page;
        logic [6:0]   faddr;
        logic [7:0]   wdog;
        logic [7:0]   presc;
        logic [31:0]  rdata;
        logic         sleep;
        logic         bsy;
        logic         rdy;
        logic         err;
    } mex_state_s;

    mex_state_s s_q;
    mex_state_s s_d;

    logic       f_we;
    logic [6:0] f_waddr;
    logic [7:0] f_wdata;
    logic [6:0] f_raddr;
    logic [7:0] f_rdata;

    function automatic logic zero_of(input logic [7:0] v);
        zero_of = (v == 8'h00);
    endfunction : zero_of

    function automatic logic [31:0] word8(input logic [7:0] v);
        word8 = {24'h000000, v};
    endfunction : word8

    function automatic logic [7:0] bump(input logic [7:0] v, input logic [7:0] mask);
        bump = (v + 8'h01) & mask;
    endfunction : bump

    // ==========================================================
    // Counter widths
    // Narrower counters keep their upper bits at zero instead of changing the struct
    localparam logic [7:0] WDOG_MASK  = 8'((1 << WDOG_W) - 1);
    localparam logic [7:0] PRESC_MASK = 8'((1 << PRESC_W) - 1);

    // ==========================================================
    // Instruction decode
    typedef enum logic [6:0] {
        MEX_K_NONE   = 7'b0000001,
        MEX_K_BRANCH = 7'b0000010,
        MEX_K_SLEEP  = 7'b0000100,
        MEX_K_ORLIT  = 7'b0001000,
        MEX_K_INCR   = 7'b0010000,
        MEX_K_ORFILE = 7'b0100000,
        MEX_K_ROTL   = 7'b1000000
    } mex_kind_e;

    // Words outside the subset fall to none and only advance the program counter
    function automatic mex_kind_e decode(input logic [13:0] w);
        if (w[13:11] == MEX_OP_BRANCH)
            decode = MEX_K_BRANCH;
        else if (w == MEX_OP_SLEEP)
            decode = MEX_K_SLEEP;
        else if (w[13:8] == MEX_OP_ORLIT)
            decode = MEX_K_ORLIT;
        else if (w[13:8] == MEX_OP_INCR)
            decode = MEX_K_INCR;
        else if (w[13:8] == MEX_OP_ORFILE)
            decode = MEX_K_ORFILE;
        else if (w[13:8] == MEX_OP_ROTL)
            decode = MEX_K_ROTL;
        else
            decode = MEX_K_NONE;
    endfunction : decode

    // ==========================================================
    // File register storage
    mex_file_ram #(
        .DEPTH (FILE_DEPTH),
        .AW    (7)
    ) u_file (
        .hclk  (hclk),
        .we    (f_we),
        .waddr (f_waddr),
        .wdata (f_wdata),
        .raddr (f_raddr),
        .rdata (f_rdata)
    );

    // ==========================================================
    // Next state
    logic        acc_wr;
    logic        acc_rd;
    logic [7:0]  res;
    logic        dest_file;
    logic        bus_we;
    logic [6:0]  fa;
    mex_kind_e   kind;
    logic        file_op;

    always_comb
    begin
        // ==========================================================
        // Defaults
        s_d       = s_q;
        f_we      = 1'b0;
        f_waddr   = s_q.faddr;
        f_wdata   = 8'h00;
        res       = 8'h00;
        kind      = decode(s_q.instr);
        file_op   = (kind == MEX_K_INCR) || (kind == MEX_K_ORFILE) || (kind == MEX_K_ROTL);
        fa        = s_q.instr[6:0];
        dest_file = s_q.instr[MEX_DEST_BIT];
        f_raddr   = (s_q.st == MEX_EXEC) ? fa : s_q.faddr;
        acc_rd    = hsel && hready && htrans[1] && !hwrite;
        acc_wr    = hsel && hready && htrans[1] && hwrite;
        bus_we    = s_q.pend;

        // ==========================================================
        // Data phase of a write: one-cycle zero-wait answer
        // An FDATA write landing in an execute cycle that writes the file is lost
        if (bus_we)
        begin
            case (s_q.paddr)
                MEX_OFF_INSTR:
                begin
                    // Writes while executing or asleep are dropped so state stays coherent
                    if (s_q.st == MEX_IDLE)
                    begin
                        s_d.instr = hwdata[13:0];
                        s_d.st    = MEX_EXEC;
                    end
                end
                MEX_OFF_WORK:   s_d.work   = hwdata[7:0];
                MEX_OFF_PC:     s_d.pc     = hwdata[12:0];
                MEX_OFF_STATUS: s_d.status = hwdata[7:0];
                MEX_OFF_PAGE:   s_d.page   = hwdata[7:0];
                MEX_OFF_FADDR:  s_d.faddr  = hwdata[6:0];
                MEX_OFF_FDATA:
                begin
                    f_we    = 1'b1;
                    f_wdata = hwdata[7:0];
                end
                MEX_OFF_CTRL:
                begin
                    // Wake-up is software's job here; no interrupt path exists
                    if (hwdata[MEX_CTRL_WAKE] && s_q.st == MEX_SLEEP)
                    begin
                        s_d.st    = MEX_IDLE;
                        s_d.sleep = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // ==========================================================
        // Execution
        case (s_q.st)
            MEX_IDLE: ;
            MEX_EXEC:
            begin
                s_d.st = MEX_IDLE;
                s_d.pc = s_q.pc + MEX_PC_STEP;
                case (kind)
                    MEX_K_BRANCH:
                    begin
                        // The flush cycle stands for the refetch that follows a jump
                        s_d.pc[10:0]  = s_q.instr[10:0];
                        s_d.pc[12:11] = s_q.page[MEX_PAGE_HI:MEX_PAGE_LO];
                        s_d.st        = MEX_FLUSH;
                    end
                    MEX_K_SLEEP:
                    begin
                        s_d.wdog                   = MEX_WDOG_ZERO;
                        s_d.presc                  = MEX_WDOG_ZERO;
                        s_d.status[MEX_ST_PWRDN_N] = 1'b0;
                        s_d.status[MEX_ST_TMOUT_N] = 1'b1;
                        s_d.st                     = MEX_SLEEP;
                        s_d.sleep                  = 1'b1;
                    end
                    MEX_K_ORLIT:
                    begin
                        res                     = s_q.work | s_q.instr[7:0];
                        s_d.work                = res;
                        s_d.status[MEX_ST_ZERO] = zero_of(res);
                    end
                    MEX_K_INCR:
                    begin
                        // The carry out of the increment is dropped: only zero is affected
                        res                     = f_rdata + 8'h01;
                        s_d.status[MEX_ST_ZERO] = zero_of(res);
                    end
                    MEX_K_ORFILE:
                    begin
                        res                     = s_q.work | f_rdata;
                        s_d.status[MEX_ST_ZERO] = zero_of(res);
                    end
                    MEX_K_ROTL:
                    begin
                        res = {f_rdata[6:0], s_q.status[MEX_ST_CARRY]};
                        s_d.status[MEX_ST_CARRY] = f_rdata[7];
                    end
                    default: ;
                endcase
                if (file_op)
                begin
                    if (dest_file)
                    begin
                        f_we    = 1'b1;
                        f_waddr = fa;
                        f_wdata = res;
                    end
                    else
                        s_d.work = res;
                end
            end
            MEX_FLUSH:  s_d.st = MEX_IDLE;
            MEX_SLEEP:  ;
            default:    s_d.st = MEX_IDLE;
        endcase

        // ==========================================================
        // Watchdog
        // Runs only in idle and flush; frozen in execute, and in sleep because the oscillator is stopped
        if (s_q.st != MEX_SLEEP && s_q.st != MEX_EXEC)
        begin
            s_d.presc = bump(s_q.presc, PRESC_MASK);
            if (s_q.presc == PRESC_MASK)
                s_d.wdog = bump(s_q.wdog, WDOG_MASK);
        end

        // ==========================================================
        // Address phase capture
        s_d.pend  = acc_wr;
        s_d.paddr = haddr[7:0];
        if (acc_rd)
        begin
            case (haddr[7:0])
                MEX_OFF_INSTR:  s_d.rdata = {18'h00000, s_q.instr};
                MEX_OFF_WORK:   s_d.rdata = word8(s_q.work);
                MEX_OFF_PC:     s_d.rdata = {19'h00000, s_q.pc};
                MEX_OFF_STATUS: s_d.rdata = word8(s_q.status);
                MEX_OFF_PAGE:   s_d.rdata = word8(s_q.page);
                MEX_OFF_FADDR:  s_d.rdata = word8({1'b0, s_q.faddr});
                MEX_OFF_FDATA:  s_d.rdata = word8(f_rdata);
                MEX_OFF_WDOG:   s_d.rdata = {16'h0000, s_q.presc, s_q.wdog};
                MEX_OFF_CTRL:   s_d.rdata = {28'h0000000, s_q.st};
                default:        s_d.rdata = 32'h00000000;
            endcase
        end
        // ==========================================================
        // Output flops
        // Bus answer is always a zero-wait OKAY, still held in flops like every output
        s_d.pwr = !s_d.sleep;
        s_d.bsy = (s_d.st != MEX_IDLE);
        s_d.rdy = 1'b1;
        s_d.err = 1'b0;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Fields with a non-zero reset value are set one by one
            s_q        <= '0;
            s_q.st     <= MEX_IDLE;
            s_q.pwr    <= 1'b1;
            s_q.rdy    <= 1'b1;
            s_q.pc     <= MEX_PC_RST;
            s_q.status <= MEX_STATUS_RST;
        end
        else
            s_q <= s_d;
    end

    // ==========================================================
    // Outputs
    assign hrdata       = s_q.rdata;
    assign hreadyout    = s_q.rdy;
    assign hresp        = s_q.err;
    assign sleep_active = s_q.sleep;
    assign osc_enable   = s_q.pwr;
    assign busy         = s_q.bsy;

endmodule : mex_core

// ### core/mex_file_ram.sv
`timescale 1ns/1ps
module mex_file_ram
    import mex_pkg::*;
#(
    parameter int DEPTH = 128,
    parameter int AW    = 7
)(
    // Clock
    input  wire logic          hclk,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);

    initial
    begin
        if (DEPTH > (1 << AW) || DEPTH < 1)
            $error("mex_file_ram: depth does not fit address");
    end

    // ==========================================================
    // Storage, no reset: contents are undefined like real file RAM
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge hclk)
    begin
        if (we)
            mem_q[waddr] <= wdata;
    end

    assign rdata = mem_q[raddr];

endmodule : mex_file_ram

// ### core/mex_pkg.sv
package mex_pkg;

    // ==========================================================
    // Widths
    localparam int MEX_DW  = 32;
    localparam int MEX_AW  = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] MEX_OFF_INSTR  = 8'h00;
    localparam logic [7:0] MEX_OFF_WORK   = 8'h04;
    localparam logic [7:0] MEX_OFF_PC     = 8'h08;
    localparam logic [7:0] MEX_OFF_STATUS = 8'h0C;
    localparam logic [7:0] MEX_OFF_PAGE   = 8'h10;
    localparam logic [7:0] MEX_OFF_FADDR  = 8'h14;
    localparam logic [7:0] MEX_OFF_FDATA  = 8'h18;
    localparam logic [7:0] MEX_OFF_WDOG   = 8'h1C;
    localparam logic [7:0] MEX_OFF_CTRL   = 8'h20;

    // ==========================================================
    // Opcode encodings, 14-bit instruction word
    localparam logic [2:0]  MEX_OP_BRANCH = 3'h5;
    localparam logic [5:0]  MEX_OP_ORLIT  = 6'h38;
    localparam logic [5:0]  MEX_OP_INCR   = 6'h0A;
    localparam logic [5:0]  MEX_OP_ORFILE = 6'h04;
    localparam logic [5:0]  MEX_OP_ROTL   = 6'h0D;
    localparam logic [13:0] MEX_OP_SLEEP  = 14'h0063;

    // ==========================================================
    // Field positions
    localparam int MEX_DEST_BIT   = 7;
    localparam int MEX_PAGE_HI    = 4;
    localparam int MEX_PAGE_LO    = 3;
    localparam int MEX_ST_CARRY   = 0;
    localparam int MEX_ST_ZERO    = 2;
    localparam int MEX_ST_PWRDN_N = 3;
    localparam int MEX_ST_TMOUT_N = 4;
    localparam int MEX_CTRL_WAKE  = 0;

    // ==========================================================
    // Reset values, program counter step and watchdog clear value
    localparam logic [7:0]  MEX_STATUS_RST = 8'h18;
    localparam logic [12:0] MEX_PC_RST     = 13'h0000;
    localparam logic [12:0] MEX_PC_STEP    = 13'h0001;
    localparam logic [7:0]  MEX_WDOG_ZERO  = 8'h00;

    // ==========================================================
    // Execution states
    typedef enum logic [3:0] {
        MEX_IDLE   = 4'b0001,
        MEX_EXEC   = 4'b0010,
        MEX_FLUSH  = 4'b0100,
        MEX_SLEEP  = 4'b1000
    } mex_state_e;

endpackage : mex_pkg

// ### verification/mex_core_bench.sv
`timescale 1ns/1ps
module mex_core_bench
    import mex_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sleep_active;
    logic        osc_enable;
    logic        busy;
    logic [31:0] rd;
    int          err_count = 0;
    int          checks_done = 0;
    logic [7:0]  pg [3] = '{8'h18, 8'h08, 8'hE7};
    logic [10:0] kk [3] = '{11'h7FF, 11'h123, 11'h000};

    always #5 hclk = ~hclk;

    mex_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sleep_active(sleep_active), .osc_enable(osc_enable), .busy(busy));

    // ====
    // Bus tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(nm, rd, exp);
    endtask : rdc

    // Polling keeps the bench free of any assumed execution length
    task automatic waitst(input logic [31:0] st);
        int n;
        n = 0;
        do
        begin
            xfer(MEX_OFF_CTRL, 1'b0, 32'h0);
            n++;
        end
        while (rd !== st && n < 20);
        chk("state", rd, st);
    endtask : waitst

    task automatic run(input logic [13:0] ins);
        xfer(MEX_OFF_INSTR, 1'b1, {18'h0, ins});
        waitst(32'h1);
    endtask : run

    task automatic summarize;
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // ====
    // Tests
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("status", MEX_OFF_STATUS, 32'h18);
        rdc("unmapped", 8'h40, 32'h0);
        xfer(MEX_OFF_STATUS, 1'b1, 32'h19);
        run({MEX_OP_ORLIT, 8'h00});
        rdc("status", MEX_OFF_STATUS, 32'h1D);
        run({MEX_OP_ORLIT, 8'hA5});
        rdc("work", MEX_OFF_WORK, 32'hA5);
        rdc("status", MEX_OFF_STATUS, 32'h19);
        xfer(MEX_OFF_FADDR, 1'b1, 32'h7F);
        xfer(MEX_OFF_FDATA, 1'b1, 32'hFF);
        run({MEX_OP_INCR, 1'b1, 7'h7F});
        rdc("fdata", MEX_OFF_FDATA, 32'h0);
        rdc("status", MEX_OFF_STATUS, 32'h1D);
        run({MEX_OP_INCR, 1'b0, 7'h7F});
        rdc("work", MEX_OFF_WORK, 32'h1);
        rdc("fdata", MEX_OFF_FDATA, 32'h0);
        xfer(MEX_OFF_FDATA, 1'b1, 32'h50);
        run({MEX_OP_ORFILE, 1'b1, 7'h7F});
        rdc("fdata", MEX_OFF_FDATA, 32'h51);
        rdc("work", MEX_OFF_WORK, 32'h1);
        // Zero flag clear with a zero result proves rotate leaves it alone
        xfer(MEX_OFF_STATUS, 1'b1, 32'h18);
        xfer(MEX_OFF_FDATA, 1'b1, 32'h80);
        run({MEX_OP_ROTL, 1'b0, 7'h7F});
        rdc("work", MEX_OFF_WORK, 32'h0);
        rdc("status", MEX_OFF_STATUS, 32'h19);
        run({MEX_OP_ROTL, 1'b1, 7'h7F});
        rdc("fdata", MEX_OFF_FDATA, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            xfer(MEX_OFF_PAGE, 1'b1, {24'h0, pg[i]});
            run({MEX_OP_BRANCH, kk[i]});
            rdc("pc", MEX_OFF_PC, {19'h0, pg[i][4:3], kk[i]});
            rdc("status", MEX_OFF_STATUS, 32'h19);
        end
        xfer(MEX_OFF_STATUS, 1'b1, 32'h0D);
        repeat (300) @(posedge hclk);
        // Watchdog must have moved, so the clear below proves something
        xfer(MEX_OFF_WDOG, 1'b0, 32'h0);
        chk("wdog running", {31'h0, rd[7:0] != 8'h00}, 32'h1);
        xfer(MEX_OFF_INSTR, 1'b1, {18'h0, MEX_OP_SLEEP});
        waitst(32'h8);
        rdc("wdog", MEX_OFF_WDOG, 32'h0);
        rdc("status", MEX_OFF_STATUS, 32'h15);
        chk("osc", {31'h0, osc_enable}, 32'h0);
        chk("sleep", {31'h0, sleep_active}, 32'h1);
        xfer(MEX_OFF_INSTR, 1'b1, {18'h0, MEX_OP_ORLIT, 8'hFF});
        rdc("work", MEX_OFF_WORK, 32'h0);
        xfer(MEX_OFF_CTRL, 1'b1, 32'h1);
        waitst(32'h1);
        chk("osc", {31'h0, osc_enable}, 32'h1);
        chk("sleep", {31'h0, sleep_active}, 32'h0);
        summarize();
    end

    initial
    begin
        #100000;
        err_count++;
        summarize();
    end
endmodule : mex_core_bench

bind mex_core mex_core_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_active(sleep_active),
    .osc_enable(osc_enable), .busy(busy));

// ### verification/mex_core_props.sv
`timescale 1ns/1ps
module mex_core_props
    import mex_pkg::*;
(
    // Bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Core side
    input wire logic        sleep_active,
    input wire logic        osc_enable,
    input wire logic        busy
);
    // ====
    // Data phase trackers
    logic ins_q;
    logic ctl_q;
    wire  acc = hsel && hready && htrans[1] && hwrite;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ins_q <= 1'b0;
            ctl_q <= 1'b0;
        end
        else
        begin
            // Writes while busy are dropped, so they launch nothing
            ins_q <= acc && haddr[7:0] == MEX_OFF_INSTR && !busy;
            ctl_q <= acc && haddr[7:0] == MEX_OFF_CTRL;
        end
    end
    // ====
    // Properties
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_one; busy ##1 !busy; endsequence
    sequence s_two; busy [*2] ##1 !busy; endsequence
    property p_branch; ins_q && hwdata[13:11] == MEX_OP_BRANCH |=> s_two; endproperty
    property p_orlit; ins_q && hwdata[13:8] == MEX_OP_ORLIT |=> s_one; endproperty
    property p_sleep; ins_q && hwdata[13:0] == MEX_OP_SLEEP |-> ##[1:3] sleep_active; endproperty
    property p_osc; sleep_active |-> !osc_enable && busy; endproperty
    property p_stay; sleep_active && !ctl_q |=> sleep_active; endproperty
    property p_wake; ctl_q && hwdata[0] && sleep_active |-> ##[1:2] osc_enable; endproperty
    property p_okay; hreadyout && !hresp; endproperty
    property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
    a_branch: assert property (p_branch)
        else $error("branch length wrong");
    a_orlit: assert property (p_orlit)
        else $error("or literal length wrong");
    a_sleep: assert property (p_sleep)
        else $error("sleep not entered");
    a_osc: assert property (p_osc)
        else $error("oscillator runs in sleep");
    a_stay: assert property (p_stay)
        else $error("sleep left early");
    a_wake: assert property (p_wake)
        else $error("no wake");
    a_okay: assert property (p_okay)
        else $error("bus not ready");
    a_hold: assert property (p_hold)
        else $error("read data moved");
endmodule : mex_core_props
